// >>> pkg/cae_defines.svh
`ifndef CAE_DEFINES_SVH
`define CAE_DEFINES_SVH
// Functional notes
// - Four levels; disabled level never alarms. With fast scan a level switched off keeps its output until the next tick.
// - Absolute high: value at/above limit.
// - Absolute low: value at/below limit.
// - Rising rate: increase reaches amount.
// - Falling rate: decrease reaches amount.
// - Delayed high: held at/above for delay.
// - Delayed low: held at/below for delay.
// - Difference high: channel difference at/above limit.
// - Difference low: channel difference at/below limit.
// - Difference modes only on delta channels.
// - Profile high: value at/above profile upper.
// - Profile low: value at/below profile lower.
// - Hysteresis only in absolute and difference modes.
// - Profile modes ignore limit and hysteresis.
// - Profile modes rejected on logarithmic channels.
// - Routing off, relay or switch; default off.
// - Relay routing needs an alarm output channel.
// - Switch routing needs an alarm internal switch.
// - Reset limit zero; current hysteresis 0.05.
// - Rate limit one digit to span.
// - Release only past limit by hysteresis.
// - Logging off still drives routed outputs.
// - Delay time, default 10 s, delayed only.
// - Fast scan: evaluate every 100 ms, capturing.
`define CAE_A_CFG 8'h00
`define CAE_A_STAT 8'h04
`define CAE_O_CTRL 2'h0
`define CAE_O_LIM 2'h1
`define CAE_O_HYS 2'h2
`define CAE_O_DLY 2'h3
`define CAE_B_EN 0
`define CAE_B_MODE 1
`define CAE_B_LOG 5
`define CAE_B_RT 6
`define CAE_B_NUM 8
`define CAE_B_DELTA 0
`define CAE_B_LOGIN 1
`define CAE_B_DOOK 2
`define CAE_B_SWOK 3
`define CAE_B_FAST 4
`define CAE_RST_LIM 32'sh00000000
`define CAE_RST_HYS_MA 32'sh00000005
`define CAE_RST_HYS 32'sh00000000
`define CAE_RST_DLY 17'h0000A
`define CAE_DLY_MAX 17'h15180
`define CAE_RNG_MAX 32'sh00004E20
`define CAE_RNG_MIN (-32'sh00004E20)
`define CAE_RNG_SPAN 32'sh00009C40
`define CAE_HYS_MAX 32'sh000186A0
`define CAE_CLK_HZ 25000000
`define CAE_EVAL_MS 100
`define CAE_SEC_MS 1000
`define CAE_EVAL_CYC (`CAE_CLK_HZ / 1000 * `CAE_EVAL_MS)
`define CAE_SEC_CYC (`CAE_CLK_HZ / 1000 * `CAE_SEC_MS)
`endif

// >>> pkg/cae_pkg.sv
package cae_pkg;
  typedef enum logic [3:0] {M_HI, M_LO, M_RISE, M_FALL, M_DHI, M_DLO, M_DFHI, M_DFLO, M_PHI, M_PLO} cae_mode_e;
  typedef enum logic [1:0] {RT_OFF, RT_RELAY, RT_SWITCH} cae_route_e;
  typedef logic signed [31:0] cae_val_t;
  typedef logic [16:0] cae_dly_t;
endpackage : cae_pkg

// >>> pkg/cae_lvl_if.sv
`timescale 1ns/1ps
interface cae_lvl_if;
  import cae_pkg::*;
  logic en;
  cae_mode_e mode;
  cae_val_t lim;
  cae_val_t hys;
  cae_dly_t dly;
  // Compared quantity: measured value, channel difference or step.
  cae_val_t val;
  cae_val_t phi;
  cae_val_t plo;
  logic alarm;
  modport ctl (output en, mode, lim, hys, dly, val, phi, plo, input alarm);
  modport lvl (input en, mode, lim, hys, dly, val, phi, plo, output alarm);
endinterface : cae_lvl_if

// >>> rtl/cae_tick.sv
`timescale 1ns/1ps
module cae_tick #(
  parameter int DIV = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Enable pulse
  output logic tick
);
  logic [31:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt == 32'(DIV - 1)) begin
      cnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule : cae_tick

// >>> rtl/cae_level.sv
`timescale 1ns/1ps
module cae_level
  import cae_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Evaluation strobe and one-second enable
  input wire logic eval,
  input wire logic sec_tick,
  // Level settings and result
  cae_lvl_if.lvl lv
);
  logic hi_mode;
  logic use_hys;
  logic delayed;
  logic cond;
  logic held;
  cae_val_t thr;
  cae_dly_t cnt;

  always_comb begin
    hi_mode = lv.mode inside {M_HI, M_RISE, M_FALL, M_DHI, M_DFHI, M_PHI};
    use_hys = lv.mode inside {M_HI, M_LO, M_DFHI, M_DFLO};
    delayed = lv.mode inside {M_DHI, M_DLO};
    thr = (lv.mode == M_PHI) ? lv.phi : (lv.mode == M_PLO) ? lv.plo : lv.lim;
    cond = hi_mode ? (lv.val >= thr) : (lv.val <= thr);
    // An active alarm holds until the value is back past the band.
    if (use_hys && lv.alarm) begin
      cond = hi_mode ? (lv.val >= thr - lv.hys) : (lv.val <= thr + lv.hys);
    end
  end

  // Seconds are counted only while the last evaluation saw the condition.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= 1'b0;
      cnt <= 17'h00000;
    end else if (!lv.en || !delayed || (eval && !cond)) begin
      held <= 1'b0;
      cnt <= 17'h00000;
    end else begin
      if (eval) begin
        held <= 1'b1;
      end
      if (held && sec_tick && cnt != 17'h1FFFF) begin
        cnt <= cnt + 17'h00001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lv.alarm <= 1'b0;
    end else if (!lv.en) begin
      lv.alarm <= 1'b0;
    end else if (eval) begin
      lv.alarm <= delayed ? (cond && held && cnt >= lv.dly) : cond;
    end
  end
endmodule : cae_level

// >>> rtl/cae_top.sv
`timescale 1ns/1ps
`include "cae_defines.svh"
module cae_top
  import cae_pkg::*;
#(
  parameter int EVAL_CYC = `CAE_EVAL_CYC,
  parameter int SEC_CYC = `CAE_SEC_CYC,
  parameter bit CURRENT_CH = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel scanner
  input wire logic meas_valid,
  input wire logic [31:0] meas_val,
  input wire logic [31:0] ref_val,
  input wire logic [31:0] prof_hi,
  input wire logic [31:0] prof_lo,
  // Alarm results
  output logic [3:0] alarm_state,
  output logic [3:0] relay_req,
  output logic [3:0] switch_req,
  output logic [3:0] summary_evt
);
  logic [4:0] cfg;
  logic [3:0] en;
  cae_mode_e mode [4];
  logic [3:0] logf;
  cae_route_e route [4];
  logic [6:0] onum [4];
  cae_val_t lim [4];
  cae_val_t hys [4];
  cae_dly_t dly [4];
  cae_val_t prev;
  logic [3:0] lvl_alm;
  logic [3:0] capt;
  logic [3:0] next_out;
  logic out_upd;
  logic eval_d;
  logic tick_eval;
  logic tick_sec;

  // Bus decode.
  logic setup;
  logic acc_wr;
  logic hit_lvl;
  logic [1:0] li;
  logic [1:0] fld;
  cae_mode_e w_mode;
  cae_route_e w_route;
  cae_val_t w_val;
  logic bad;
  logic [31:0] rdata;

  cae_lvl_if lif[4] ();

  cae_tick #(
    .DIV(EVAL_CYC)
  ) u_tick_eval (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_eval)
  );

  cae_tick #(
    .DIV(SEC_CYC)
  ) u_tick_sec (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_sec)
  );

  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pready && pwrite && !pslverr;
  assign hit_lvl = (paddr[7:4] >= 4'h1) && (paddr[7:4] <= 4'h4) && (paddr[1:0] == 2'h0);
  assign li = 2'(paddr[7:4] - 4'h1);
  assign fld = paddr[3:2];
  assign w_mode = cae_mode_e'(pwdata[`CAE_B_MODE +: 4]);
  assign w_route = cae_route_e'(pwdata[`CAE_B_RT +: 2]);
  assign w_val = cae_val_t'(pwdata);

  // Writes that the channel setup does not allow answer with an error and change nothing.
  always_comb begin
    bad = 1'b0;
    rdata = 32'h00000000;
    if (paddr == `CAE_A_CFG) begin
      rdata = {27'h0000000, cfg};
    end else if (paddr == `CAE_A_STAT) begin
      rdata = {24'h000000, alarm_state & logf, alarm_state};
      bad = pwrite;
    end else if (hit_lvl) begin
      case (fld)
        `CAE_O_CTRL: begin
          rdata = {17'h00000, onum[li], route[li], logf[li], mode[li], en[li]};
          bad = pwrite && (w_mode > M_PLO || w_route > RT_SWITCH);
          if (pwrite && w_mode inside {M_DFHI, M_DFLO} && !cfg[`CAE_B_DELTA]) begin
            bad = 1'b1;
          end
          if (pwrite && w_mode inside {M_PHI, M_PLO} && cfg[`CAE_B_LOGIN]) begin
            bad = 1'b1;
          end
          if (pwrite && w_route == RT_RELAY && !cfg[`CAE_B_DOOK]) begin
            bad = 1'b1;
          end
          if (pwrite && w_route == RT_SWITCH && !cfg[`CAE_B_SWOK]) begin
            bad = 1'b1;
          end
        end
        `CAE_O_LIM: begin
          rdata = lim[li];
          if (pwrite) begin
            if (!en[li] || mode[li] inside {M_PHI, M_PLO}) begin
              bad = 1'b1;
            end else if (mode[li] inside {M_RISE, M_FALL}) begin
              bad = (w_val < 32'sh00000001) || (w_val > `CAE_RNG_SPAN);
            end else if (mode[li] inside {M_DFHI, M_DFLO}) begin
              bad = (w_val < -`CAE_RNG_SPAN) || (w_val > `CAE_RNG_SPAN);
            end else begin
              bad = (w_val < `CAE_RNG_MIN) || (w_val > `CAE_RNG_MAX);
            end
          end
        end
        `CAE_O_HYS: begin
          rdata = hys[li];
          if (pwrite) begin
            bad = !en[li] || !(mode[li] inside {M_HI, M_LO, M_DFHI, M_DFLO}) ||
                  (w_val < 32'sh00000000) || (w_val > `CAE_HYS_MAX);
          end
        end
        default: begin
          rdata = {15'h0000, dly[li]};
          bad = pwrite && (!en[li] || pwdata > 32'(`CAE_DLY_MAX));
        end
      endcase
    end else begin
      bad = 1'b1;
    end
  end

  // Answer is ready in the first access cycle; data and error are settled in setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= bad;
      prdata <= (pwrite || bad) ? 32'h00000000 : rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= 5'h00;
    end else if (acc_wr && paddr == `CAE_A_CFG) begin
      cfg <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en <= 4'h0;
      logf <= 4'hF;
      for (int i = 0; i < 4; i++) begin
        mode[i] <= M_HI;
        route[i] <= RT_OFF;
        onum[i] <= 7'h00;
        lim[i] <= `CAE_RST_LIM;
        hys[i] <= CURRENT_CH ? `CAE_RST_HYS_MA : `CAE_RST_HYS;
        dly[i] <= `CAE_RST_DLY;
      end
    end else if (acc_wr && hit_lvl) begin
      case (fld)
        `CAE_O_CTRL: begin
          en[li] <= pwdata[`CAE_B_EN];
          mode[li] <= w_mode;
          logf[li] <= pwdata[`CAE_B_LOG];
          route[li] <= w_route;
          onum[li] <= pwdata[`CAE_B_NUM +: 7];
        end
        `CAE_O_LIM: lim[li] <= w_val;
        `CAE_O_HYS: hys[li] <= w_val;
        default: dly[li] <= pwdata[16:0];
      endcase
    end
  end

  // Rate modes compare against the previous scan, so the interval is one scan.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 32'sh00000000;
    end else if (meas_valid) begin
      prev <= meas_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eval_d <= 1'b0;
    end else begin
      eval_d <= meas_valid;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_lvl
    assign lif[g].en = en[g];
    assign lif[g].mode = mode[g];
    assign lif[g].lim = lim[g];
    assign lif[g].hys = hys[g];
    assign lif[g].dly = dly[g];
    assign lif[g].phi = prof_hi;
    assign lif[g].plo = prof_lo;
    assign lvl_alm[g] = lif[g].alarm;

    always_comb begin
      case (mode[g])
        M_RISE: lif[g].val = meas_val - prev;
        M_FALL: lif[g].val = prev - meas_val;
        M_DFHI, M_DFLO: lif[g].val = meas_val - ref_val;
        default: lif[g].val = meas_val;
      endcase
    end

    cae_level u_level (
      .pclk(pclk),
      .presetn(presetn),
      .eval(meas_valid),
      .sec_tick(tick_sec),
      .lv(lif[g])
    );
  end

  // Fast scans gather every alarm seen in the window; the window edge takes a new one too.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capt <= 4'h0;
    end else if (!cfg[`CAE_B_FAST] || tick_eval) begin
      capt <= 4'h0;
    end else if (eval_d) begin
      capt <= capt | lvl_alm;
    end
  end

  always_comb begin
    next_out = alarm_state;
    out_upd = 1'b0;
    if (cfg[`CAE_B_FAST]) begin
      if (tick_eval) begin
        next_out = (capt | (eval_d ? lvl_alm : 4'h0)) & en;
        out_upd = 1'b1;
      end
    end else if (eval_d) begin
      next_out = lvl_alm & en;
      out_upd = 1'b1;
    end else begin
      // Without fast scan a level switched off drops its output at once; with fast scan its output holds until the next tick.
      next_out = alarm_state & en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_state <= 4'h0;
      relay_req <= 4'h0;
      switch_req <= 4'h0;
      summary_evt <= 4'h0;
    end else begin
      alarm_state <= next_out;
      for (int i = 0; i < 4; i++) begin
        relay_req[i] <= next_out[i] && route[i] == RT_RELAY;
        switch_req[i] <= next_out[i] && route[i] == RT_SWITCH;
        summary_evt[i] <= out_upd && next_out[i] && !alarm_state[i] && logf[i];
      end
    end
  end

  property p_cfg_delta;
    @(posedge pclk) disable iff (!presetn)
      setup && pwrite && hit_lvl && fld == `CAE_O_CTRL && w_mode inside {M_DFHI, M_DFLO} &&
      !cfg[`CAE_B_DELTA] |=> pslverr ##1 $stable(mode[li]);
  endproperty
  a_cfg_delta: assert property (p_cfg_delta) else $error("difference mode taken on non-delta channel");

  property p_cfg_log;
    @(posedge pclk) disable iff (!presetn)
      setup && pwrite && hit_lvl && fld == `CAE_O_CTRL && w_mode inside {M_PHI, M_PLO} &&
      cfg[`CAE_B_LOGIN] |=> pslverr;
  endproperty
  a_cfg_log: assert property (p_cfg_log) else $error("profile mode not refused on log channel");

  property p_cfg_relay;
    @(posedge pclk) disable iff (!presetn)
      setup && pwrite && hit_lvl && fld == `CAE_O_CTRL && w_route == RT_RELAY &&
      !cfg[`CAE_B_DOOK] |=> pslverr && pready;
  endproperty
  a_cfg_relay: assert property (p_cfg_relay) else $error("relay routing not refused");

  property p_cfg_sw;
    @(posedge pclk) disable iff (!presetn)
      setup && pwrite && hit_lvl && fld == `CAE_O_CTRL && w_route == RT_SWITCH &&
      !cfg[`CAE_B_SWOK] |=> pslverr;
  endproperty
  a_cfg_sw: assert property (p_cfg_sw) else $error("switch routing not refused");

  property p_rate_lim;
    @(posedge pclk) disable iff (!presetn)
      setup && pwrite && hit_lvl && fld == `CAE_O_LIM && mode[li] inside {M_RISE, M_FALL} &&
      w_val < 32'sh00000001 |=> pslverr;
  endproperty
  a_rate_lim: assert property (p_rate_lim) else $error("rate limit below one digit accepted");

  for (genvar g = 0; g < 4; g++) begin : g_chk
    property p_off;
      @(posedge pclk) disable iff (!presetn)
        !en[g] |=> !lvl_alm[g] ##1 !relay_req[g] && !switch_req[g];
    endproperty
    a_off: assert property (p_off) else $error("disabled level raised an alarm");

    property p_hi;
      @(posedge pclk) disable iff (!presetn)
        meas_valid && en[g] && mode[g] == M_HI && $signed(meas_val) >= lim[g] |=> lvl_alm[g];
    endproperty
    a_hi: assert property (p_hi) else $error("high limit alarm missing");

    property p_lo;
      @(posedge pclk) disable iff (!presetn)
        meas_valid && en[g] && mode[g] == M_LO && $signed(meas_val) <= lim[g] |=> lvl_alm[g];
    endproperty
    a_lo: assert property (p_lo) else $error("low limit alarm missing");

    property p_rise_clear;
      @(posedge pclk) disable iff (!presetn)
        meas_valid && en[g] && mode[g] == M_RISE && $signed(meas_val - prev) < lim[g] |=> !lvl_alm[g];
    endproperty
    a_rise_clear: assert property (p_rise_clear) else $error("rate alarm did not clear");

    property p_hys_hold;
      @(posedge pclk) disable iff (!presetn)
        meas_valid && en[g] && mode[g] == M_HI && lvl_alm[g] &&
        $signed(meas_val) >= lim[g] - hys[g] |=> lvl_alm[g];
    endproperty
    a_hys_hold: assert property (p_hys_hold) else $error("alarm released inside hysteresis band");

    property p_dly_rise;
      @(posedge pclk) disable iff (!presetn)
        en[g] && mode[g] == M_DHI && $rose(lvl_alm[g]) |-> $past(meas_valid) && $past(lif[g].val) >= lim[g];
    endproperty
    a_dly_rise: assert property (p_dly_rise) else $error("delayed alarm without condition");

    property p_log_off;
      @(posedge pclk) disable iff (!presetn)
        summary_evt[g] |-> $past(logf[g]) && alarm_state[g];
    endproperty
    a_log_off: assert property (p_log_off) else $error("unlogged alarm reported");

    property p_fast_hold;
      @(posedge pclk) disable iff (!presetn)
        cfg[`CAE_B_FAST] && !tick_eval ##1 cfg[`CAE_B_FAST] |-> $stable(alarm_state[g]);
    endproperty
    a_fast_hold: assert property (p_fast_hold) else $error("output changed between evaluation ticks");
  end
endmodule : cae_top

// >>> tb/cae_scanner.sv
`timescale 1ns/1ps
module cae_scanner (
  // Clock
  input wire logic pclk,
  // Sample stream and profile limits
  output logic meas_valid,
  output logic [31:0] meas_val,
  output logic [31:0] ref_val,
  output logic [31:0] prof_hi,
  output logic [31:0] prof_lo
);
  initial begin
    meas_valid = 1'b0;
    meas_val = 32'h0;
    ref_val = 32'h0;
    prof_hi = 32'h0;
    prof_lo = 32'h0;
  end

  // Values are only meaningful with the strobe, so the inverse is shown afterwards to expose a late capture.
  // The idle cycle keeps strobes two cycles apart.
  task automatic smp(input logic [31:0] v, input logic [31:0] r);
    meas_valid <= 1'b1;
    meas_val <= v;
    ref_val <= r;
    @(posedge pclk);
    meas_valid <= 1'b0;
    meas_val <= ~v;
    ref_val <= ~r;
    @(posedge pclk);
  endtask : smp

  task automatic prof(input logic [31:0] h, input logic [31:0] l);
    prof_hi <= h;
    prof_lo <= l;
  endtask : prof
endmodule : cae_scanner

// >>> tb/channel_alarm_evaluator_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
  samples_checked++; \
  if ((gt) !== (ex)) begin \
    fail_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); \
  end \
end
module channel_alarm_evaluator_tb;
  import cae_pkg::*;
  typedef struct {logic [3:0] m; logic [31:0] lim, v1, r1, v2, r2; logic x;} cae_case_s;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, meas_val, ref_val, prof_hi, prof_lo;
  logic pready, pslverr, meas_valid;
  logic [3:0] alarm_state, relay_req, switch_req, summary_evt;
  int fail_count = 0;
  int samples_checked = 0;
  int evt_cnt = 0;
  int hi_cnt = 0;
  int e0;
  cae_case_s tc[11];

  cae_top #(.EVAL_CYC(20), .SEC_CYC(10), .CURRENT_CH(1'b0)) cae_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_valid(meas_valid), .meas_val(meas_val), .ref_val(ref_val), .prof_hi(prof_hi),
    .prof_lo(prof_lo), .alarm_state(alarm_state), .relay_req(relay_req),
    .switch_req(switch_req), .summary_evt(summary_evt));
  cae_scanner cae_scanner_inst (.pclk(pclk), .meas_valid(meas_valid), .meas_val(meas_val),
    .ref_val(ref_val), .prof_hi(prof_hi), .prof_lo(prof_lo));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (summary_evt[0]) evt_cnt++;
    if (alarm_state[0]) hi_cnt++;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    `CHK("pslverr", ee, e)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK("pslverr", ee, e)
    if (!ee) `CHK("prdata", x, q)
  endtask : rd

  // Waits until the result of the sample has landed and any summary pulse has been counted.
  task automatic sc(input logic [31:0] v, input logic [31:0] r);
    cae_scanner_inst.smp(v, r);
    repeat (2) @(posedge pclk);
  endtask : sc

  function automatic logic [31:0] ctl(input logic [3:0] m, input logic lg, input logic [1:0] rt);
    return {24'h0, rt, lg, m, 1'b1};
  endfunction : ctl

  initial begin
    #(40 * 20000);
    fail_count++;
    stop_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tc = '{'{4'h1, 32'h32, 32'h3C, 32'h0, 32'h32, 32'h0, 1'b1}, '{4'h1, 32'h32, 32'h32, 32'h0, 32'h33, 32'h0, 1'b0},
           '{4'h2, 32'hA, 32'h0, 32'h0, 32'hA, 32'h0, 1'b1}, '{4'h2, 32'hA, 32'h0, 32'h0, 32'h9, 32'h0, 1'b0},
           '{4'h3, 32'hA, 32'h14, 32'h0, 32'hA, 32'h0, 1'b1}, '{4'h3, 32'hA, 32'h14, 32'h0, 32'hB, 32'h0, 1'b0},
           '{4'h6, 32'hC8, 32'h0, 32'h0, 32'h12C, 32'h64, 1'b1}, '{4'h6, 32'hC8, 32'h0, 32'h0, 32'h12B, 32'h64, 1'b0},
           '{4'h7, 32'hFFFFFFFB, 32'h9, 32'h0, 32'h0, 32'h5, 1'b1}, '{4'h8, 32'h0, 32'h0, 32'h0, 32'h46, 32'h0, 1'b1},
           '{4'h9, 32'h0, 32'h0, 32'h0, 32'hFFFFFFE2, 32'h0, 1'b1}};
    repeat (12) @(posedge pclk);
    `CHK("alarm_state", 4'h0, alarm_state)
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 32'h0, 1'b0);
    rd(8'h10, 32'h20, 1'b0);
    rd(8'h14, 32'h0, 1'b0);
    rd(8'h18, 32'h0, 1'b0);
    rd(8'h1C, 32'hA, 1'b0);
    rd(8'hFC, 32'h0, 1'b1);
    wr(8'h04, 32'h1, 1'b1);
    wr(8'h14, 32'h5, 1'b1);
    wr(8'h10, ctl(4'h0, 1'b1, 2'h1), 1'b1);
    wr(8'h10, ctl(4'h0, 1'b1, 2'h2), 1'b1);
    wr(8'h10, ctl(4'h6, 1'b1, 2'h0), 1'b1);
    wr(8'h00, 32'h0E, 1'b0);
    wr(8'h10, ctl(4'h8, 1'b1, 2'h0), 1'b1);
    wr(8'h00, 32'h0D, 1'b0);
    // Absolute high with hysteresis, routed to a relay and logged.
    wr(8'h10, ctl(4'h0, 1'b1, 2'h1), 1'b0);
    wr(8'h14, 32'h64, 1'b0);
    wr(8'h18, 32'hA, 1'b0);
    sc(32'h63, 32'h0);
    `CHK("alarm_state", 4'h0, alarm_state)
    e0 = evt_cnt;
    sc(32'h64, 32'h0);
    `CHK("alarm_state", 4'h1, alarm_state)
    `CHK("relay_req", 4'h1, relay_req)
    `CHK("summary", 1, evt_cnt - e0)
    rd(8'h04, 32'h11, 1'b0);
    sc(32'h5A, 32'h0);
    `CHK("alarm_state", 4'h1, alarm_state)
    sc(32'h59, 32'h0);
    `CHK("alarm_state", 4'h0, alarm_state)
    // Unlogged level still drives its switch.
    wr(8'h10, ctl(4'h0, 1'b0, 2'h2), 1'b0);
    e0 = evt_cnt;
    sc(32'h64, 32'h0);
    `CHK("switch_req", 4'h1, switch_req)
    `CHK("relay_req", 4'h0, relay_req)
    `CHK("summary", 0, evt_cnt - e0)
    rd(8'h04, 32'h01, 1'b0);
    wr(8'h10, 32'h0, 1'b0);
    repeat (3) @(posedge pclk);
    `CHK("alarm_state", 4'h0, alarm_state)
    wr(8'h20, ctl(4'h2, 1'b1, 2'h0), 1'b0);
    wr(8'h24, 32'h0, 1'b1);
    wr(8'h24, 32'h9C41, 1'b1);
    wr(8'h28, 32'h5, 1'b1);
    cae_scanner_inst.prof(32'h46, 32'hFFFFFFE2);
    foreach (tc[i]) begin
      wr(8'h20, ctl(tc[i].m, 1'b1, 2'h0), 1'b0);
      wr(8'h24, tc[i].lim, tc[i].m >= 4'h8);
      sc(tc[i].v1, tc[i].r1);
      sc(tc[i].v2, tc[i].r2);
      `CHK("mode alarm", tc[i].x, alarm_state[1])
    end
    wr(8'h20, 32'h0, 1'b0);
    // Delayed modes: two seconds of one-second ticks before the flag may rise.
    for (int m = 4; m < 6; m++) begin
      wr(8'h30, ctl(m[3:0], 1'b1, 2'h0), 1'b0);
      wr(8'h34, 32'h28, 1'b0);
      wr(8'h38, 32'h1, 1'b1);
      wr(8'h3C, 32'h2, 1'b0);
      sc(32'h28, 32'h0);
      `CHK("delay early", 1'b0, alarm_state[2])
      repeat (6) begin
        sc(32'h28, 32'h0);
        repeat (4) @(posedge pclk);
      end
      `CHK("delay late", 1'b1, alarm_state[2])
      sc((m == 4) ? 32'h27 : 32'h29, 32'h0);
      `CHK("delay clear", 1'b0, alarm_state[2])
    end
    wr(8'h30, 32'h0, 1'b0);
    // Fast scan: a short excursion must still reach the output at the next tick.
    wr(8'h00, 32'h1D, 1'b0);
    wr(8'h10, ctl(4'h0, 1'b1, 2'h0), 1'b0);
    wr(8'h14, 32'h64, 1'b0);
    wr(8'h18, 32'h0, 1'b0);
    e0 = hi_cnt;
    sc(32'h96, 32'h0);
    sc(32'h0, 32'h0);
    repeat (50) @(posedge pclk);
    `CHK("fast capture", 1'b1, hi_cnt > e0)
    `CHK("alarm_state", 4'h0, alarm_state)
    stop_test();
  end
endmodule : channel_alarm_evaluator_tb
